//--- rtl/fre_defs.svh
/*
  Constants of the file-register and jump execution block: opcode
  fields, register offsets, reset values and bus encodings.
  Assumes inclusion by the package and by the design modules.
*/
`ifndef FRE_DEFS_SVH
`define FRE_DEFS_SVH

// ****************************************
// Instruction word fields
// ****************************************
`define FRE_INSTR_W 14
`define FRE_FADDR_W 7
`define FRE_DATA_W 8
`define FRE_PC_W 15
`define FRE_LATCH_W 7
`define FRE_OPC_HI 13
`define FRE_OPC_LO 8
`define FRE_DEST_BIT 7
`define FRE_JOPC_LO 11
`define FRE_K_HI 10
`define FRE_LATCH_HI 6
`define FRE_LATCH_LO 3

// ****************************************
// Opcode patterns
// ****************************************
`define FRE_OPC_CLR 6'h01
`define FRE_OPC_DECREMENT_FILE 6'h03
`define FRE_OPC_COMPLEMENT_FILE 6'h09
`define FRE_OPC_DECREMENT_SKIP_ZERO 6'h0B
`define FRE_OPC_INCREMENT_SKIP_ZERO 6'h0F
`define FRE_OPC_JUMP 3'h5

// ****************************************
// Register offsets and reset values
// ****************************************
`define FRE_OFF_ACC 8'h00
`define FRE_OFF_STATUS 8'h04
`define FRE_OFF_LATCH 8'h08
`define FRE_OFF_PC 8'h0C
`define FRE_OFF_HI 7
`define FRE_ACC_RST 8'h00
`define FRE_LATCH_RST 7'h00
`define FRE_PC_RST 15'h0000

// ****************************************
// Data values and bus encodings
// ****************************************
`define FRE_ZERO8 8'h00
`define FRE_ONE8 8'h01
`define FRE_ONES8 8'hFF
`define FRE_RD_ZERO 32'h0000_0000
`define FRE_HTRANS_ACT 1
`define FRE_HRESP_OKAY 1'h0

`endif

//--- rtl/fre_pkg.sv
/*
  Types of the file-register and jump execution block: operation
  enumeration and the packed state of the top module.
  Assumes fre_defs.svh on the include path.
*/
`include "fre_defs.svh"

package fre_pkg;

  typedef enum logic [2:0]
  {
    FRE_OP_NONE = 3'h0,
    FRE_OP_COMPLEMENT_FILE = 3'h1,
    FRE_OP_CLEAR_FILE = 3'h2,
    FRE_OP_DECREMENT_FILE = 3'h3,
    FRE_OP_CLEAR_ACCUMULATOR = 3'h4,
    FRE_OP_DECSZ = 3'h5,
    FRE_OP_INCSZ = 3'h6,
    FRE_OP_JUMP = 3'h7
  } fre_op_t;

  typedef struct packed
  {
    logic [`FRE_DATA_W-1:0] acc;
    logic zero;
    logic [`FRE_LATCH_W-1:0] latch;
    logic [`FRE_PC_W-1:0] pc;
    logic pc_load;
    logic discard;
    logic file_we;
    logic [`FRE_FADDR_W-1:0] file_addr;
    logic [`FRE_DATA_W-1:0] file_wdata;
    logic dp_wr;
    logic [`FRE_OFF_HI:0] dp_addr;
    logic [31:0] hrdata;
  } fre_state_t;

endpackage

//--- rtl/fre_alu.sv
/*
  Decoder and arithmetic of the execution block: classifies one
  instruction word and computes its 8-bit result and side effects.
  Assumes the operand is the content of the addressed file register.
*/
`timescale 1ns/10ps
`include "fre_defs.svh"

module fre_alu
  import fre_pkg::*;
(
  // Instruction and operand
  input wire logic [`FRE_INSTR_W-1:0] instr_in,
  input wire logic [`FRE_DATA_W-1:0] operand_in,
  // Decoded results
  output fre_pkg::fre_op_t op_out,
  output logic [`FRE_DATA_W-1:0] result_out,
  output logic to_file_out,
  output logic to_acc_out,
  output logic zero_upd_out,
  output logic zero_val_out,
  output logic skip_out
);

  logic [5:0] opc;
  logic dest;

  assign opc = instr_in[`FRE_OPC_HI:`FRE_OPC_LO];
  assign dest = instr_in[`FRE_DEST_BIT];

  // ****************************************
  // Decode
  // ****************************************
  always_comb
  begin
    if (instr_in[`FRE_OPC_HI:`FRE_JOPC_LO] == `FRE_OPC_JUMP)
      op_out = FRE_OP_JUMP;
    else
    begin
      case (opc)
        `FRE_OPC_CLR: op_out = dest ? FRE_OP_CLEAR_FILE : FRE_OP_CLEAR_ACCUMULATOR;
        `FRE_OPC_DECREMENT_FILE: op_out = FRE_OP_DECREMENT_FILE;
        `FRE_OPC_COMPLEMENT_FILE: op_out = FRE_OP_COMPLEMENT_FILE;
        `FRE_OPC_DECREMENT_SKIP_ZERO: op_out = FRE_OP_DECSZ;
        `FRE_OPC_INCREMENT_SKIP_ZERO: op_out = FRE_OP_INCSZ;
        default: op_out = FRE_OP_NONE;
      endcase
    end
  end

  // ****************************************
  // Result and effects
  // ****************************************
  always_comb
  begin
    result_out = `FRE_ZERO8;
    to_file_out = 1'b0;
    to_acc_out = 1'b0;
    zero_upd_out = 1'b0;
    skip_out = 1'b0;
    case (op_out)
      FRE_OP_COMPLEMENT_FILE:
      begin
        result_out = ~operand_in;
        to_file_out = dest;
        to_acc_out = !dest;
        zero_upd_out = 1'b1;
      end
      FRE_OP_CLEAR_FILE:
      begin
        to_file_out = 1'b1;
        zero_upd_out = 1'b1;
      end
      FRE_OP_DECREMENT_FILE:
      begin
        result_out = operand_in - `FRE_ONE8;
        to_file_out = dest;
        to_acc_out = !dest;
        zero_upd_out = 1'b1;
      end
      FRE_OP_CLEAR_ACCUMULATOR:
      begin
        to_acc_out = 1'b1;
        zero_upd_out = 1'b1;
      end
      FRE_OP_DECSZ:
      begin
        result_out = operand_in - `FRE_ONE8;
        to_file_out = dest;
        to_acc_out = !dest;
        skip_out = (result_out == `FRE_ZERO8);
      end
      FRE_OP_INCSZ:
      begin
        result_out = operand_in + `FRE_ONE8;
        to_file_out = dest;
        to_acc_out = !dest;
        skip_out = (result_out == `FRE_ZERO8);
      end
      default:
      begin
        result_out = `FRE_ZERO8;
      end
    endcase
  end

  // Zero flag from the 8-bit result; clears set it too
  assign zero_val_out = (result_out == `FRE_ZERO8);

endmodule

//--- rtl/fre_exec.sv
/*
  Execution block for complement, clear, decrement, skip-on-zero and
  absolute jump instructions, with an AHB-Lite register slave.
  Assumes file_rdata_in holds the register addressed by instr_in[6:0]
  in the cycle where instr_valid_in is high.
*/
//
// Summary of operation
// - Complement file register into selected destination, update zero
// - Clear file register and set zero flag
// - Decrement file register into selected destination, update zero
// - Clear accumulator and set zero flag
// - Decrement, write destination, skip next when zero
// - Increment, write destination, skip next when zero
// - Jump loads eleven-bit literal into low PC
// - Jump fills PC 14:11 from latch 6:3
`timescale 1ns/10ps
`include "fre_defs.svh"

module fre_exec
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Instruction stream
  input wire logic instr_valid_in,
  input wire logic [`FRE_INSTR_W-1:0] instr_in,
  input wire logic [`FRE_DATA_W-1:0] file_rdata_in,
  // Data memory write
  output logic file_we_out,
  output logic [`FRE_FADDR_W-1:0] file_addr_out,
  output logic [`FRE_DATA_W-1:0] file_wdata_out,
  // Core state
  output logic [`FRE_DATA_W-1:0] acc_out,
  output logic zero_out,
  output logic [`FRE_PC_W-1:0] pc_out,
  output logic pc_load_out,
  output logic discard_out,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out
);

  import fre_pkg::*;

  fre_pkg::fre_state_t s_reg;
  fre_pkg::fre_state_t s_next;
  fre_op_t op;
  logic [`FRE_DATA_W-1:0] result;
  logic to_file;
  logic to_acc;
  logic zero_upd;
  logic zero_val;
  logic skip;
  logic exec;
  logic addr_ph;

  fre_alu u_alu
  (
    .instr_in(instr_in),
    .operand_in(file_rdata_in),
    .op_out(op),
    .result_out(result),
    .to_file_out(to_file),
    .to_acc_out(to_acc),
    .zero_upd_out(zero_upd),
    .zero_val_out(zero_val),
    .skip_out(skip)
  );

  // A discarded word executes as a no-operation
  assign exec = instr_valid_in && !s_reg.discard;
  assign addr_ph = hsel_in && hready_in && htrans_in[`FRE_HTRANS_ACT];

  function automatic logic [31:0] fre_read(input fre_state_t st,
                                           input logic [7:0] a);
    case (a)
      `FRE_OFF_ACC: fre_read = {24'h00_0000, st.acc};
      `FRE_OFF_STATUS: fre_read = {31'h0000_0000, st.zero};
      `FRE_OFF_LATCH: fre_read = {25'h000_0000, st.latch};
      `FRE_OFF_PC: fre_read = {17'h0_0000, st.pc};
      default: fre_read = `FRE_RD_ZERO;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.file_we = 1'b0;
    s_next.pc_load = 1'b0;
    // Bus data phase write
    if (s_reg.dp_wr)
    begin
      case (s_reg.dp_addr)
        `FRE_OFF_ACC: s_next.acc = hwdata_in[`FRE_DATA_W-1:0];
        `FRE_OFF_STATUS: s_next.zero = hwdata_in[0];
        `FRE_OFF_LATCH: s_next.latch = hwdata_in[`FRE_LATCH_W-1:0];
        default: s_next.zero = s_next.zero;
      endcase
    end
    // Each valid word consumes a pending discard
    if (instr_valid_in)
      s_next.discard = 1'b0;
    // Core execution wins over a same-cycle bus write
    if (exec)
    begin
      if (to_file)
      begin
        s_next.file_we = 1'b1;
        s_next.file_addr = instr_in[`FRE_FADDR_W-1:0];
        s_next.file_wdata = result;
      end
      if (to_acc)
        s_next.acc = result;
      if (zero_upd)
        s_next.zero = zero_val;
      if (skip)
        s_next.discard = 1'b1;
      if (op == FRE_OP_JUMP)
      begin
        s_next.pc = {s_reg.latch[`FRE_LATCH_HI:`FRE_LATCH_LO],
                     instr_in[`FRE_K_HI:0]};
        s_next.pc_load = 1'b1;
        s_next.discard = 1'b1;
      end
    end
    // Address phase capture and read data
    s_next.dp_wr = addr_ph && hwrite_in;
    if (addr_ph)
    begin
      s_next.dp_addr = {haddr_in[`FRE_OFF_HI:2], 2'h0};
      if (!hwrite_in)
        s_next.hrdata = fre_read(s_next, {haddr_in[`FRE_OFF_HI:2], 2'h0});
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign file_we_out = s_reg.file_we;
  assign file_addr_out = s_reg.file_addr;
  assign file_wdata_out = s_reg.file_wdata;
  assign acc_out = s_reg.acc;
  assign zero_out = s_reg.zero;
  assign pc_out = s_reg.pc;
  assign pc_load_out = s_reg.pc_load;
  assign discard_out = s_reg.discard;
  assign hreadyout_out = 1'b1;
  assign hresp_out = `FRE_HRESP_OKAY;
  assign hrdata_out = s_reg.hrdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic [3:0] latch_hi;
  assign latch_hi = s_reg.latch[`FRE_LATCH_HI:`FRE_LATCH_LO];

  a_complement_file_file_inv: assert property (
    exec && op == FRE_OP_COMPLEMENT_FILE && instr_in[`FRE_DEST_BIT]
    |=> file_we_out && file_wdata_out == ~$past(file_rdata_in))
    else $error("complement to file wrong");

  a_clear_file_sets_zero: assert property (
    exec && op == FRE_OP_CLEAR_FILE
    |=> file_we_out && file_wdata_out == `FRE_ZERO8 && zero_out)
    else $error("clear file wrong");

  a_decrement_file_acc_value: assert property (
    exec && op == FRE_OP_DECREMENT_FILE && !instr_in[`FRE_DEST_BIT]
    |=> !file_we_out && acc_out == 8'($past(file_rdata_in) - `FRE_ONE8))
    else $error("decrement to accumulator wrong");

  a_clear_accumulator_acc_zero: assert property (
    exec && op == FRE_OP_CLEAR_ACCUMULATOR |=> acc_out == `FRE_ZERO8 && zero_out)
    else $error("clear accumulator wrong");

  a_decsz_skip_next: assert property (
    exec && op == FRE_OP_DECSZ && file_rdata_in == `FRE_ONE8
    |=> discard_out and (instr_valid_in |=> !file_we_out && !discard_out))
    else $error("decrement skip not taken");

  a_incsz_skip_next: assert property (
    exec && op == FRE_OP_INCSZ && file_rdata_in != `FRE_ONES8
    |=> !discard_out)
    else $error("increment skip taken wrongly");

  a_jump_low_bits: assert property (
    exec && op == FRE_OP_JUMP
    |=> pc_load_out && pc_out[`FRE_K_HI:0] == $past(instr_in[`FRE_K_HI:0]))
    else $error("jump low bits wrong");

  a_jump_high_bits: assert property (
    exec && op == FRE_OP_JUMP
    |=> pc_out[`FRE_PC_W-1:`FRE_JOPC_LO] == $past(latch_hi))
    else $error("jump high bits wrong");

  a_zero_from_result: assert property (
    exec && (op == FRE_OP_COMPLEMENT_FILE || op == FRE_OP_DECREMENT_FILE)
    |=> zero_out == ($past(file_rdata_in) ==
        ($past(op) == FRE_OP_COMPLEMENT_FILE ? `FRE_ONES8 : `FRE_ONE8)))
    else $error("zero flag mismatch");

  a_jump_flushes: assert property (
    exec && op == FRE_OP_JUMP |=> discard_out && !file_we_out)
    else $error("jump did not flush");

  c_jump_taken: cover property (exec && op == FRE_OP_JUMP);
  c_skip_taken: cover property (exec && skip);
  c_discard_used: cover property (discard_out && instr_valid_in);
  c_bus_read: cover property (addr_ph && !hwrite_in);

endmodule

//--- verification/fre_mem_model.sv
/*
  Data memory and operand source facing the execution block.
  Assumes writes arrive as one-cycle pulses at the rising clock.
*/
`timescale 1ns/10ps
`include "fre_defs.svh"

module fre_mem_model
(
  // Clock
  input wire logic mclk_in,
  // Operand read
  input wire logic valid_in,
  input wire logic [`FRE_FADDR_W-1:0] raddr_in,
  output logic [`FRE_DATA_W-1:0] rdata_out,
  // Write back
  input wire logic we_in,
  input wire logic [`FRE_FADDR_W-1:0] waddr_in,
  input wire logic [`FRE_DATA_W-1:0] wdata_in
);
  logic [`FRE_DATA_W-1:0] mem [0:127];

  // Operand only meaningful while valid; inverted otherwise
  assign rdata_out = valid_in ? mem[raddr_in] : ~mem[raddr_in];

  always @(posedge mclk_in)
  begin
    if (we_in)
      mem[waddr_in] <= wdata_in;
  end
endmodule

//--- verification/file_register_op_and_jump_exec_tb_top.sv
/*
  Self-checking bench of the execution block.
  Assumes fre_exec answers one cycle after a taken word.
*/
`timescale 1ns/10ps
`include "fre_defs.svh"

module file_register_op_and_jump_exec_tb_top;
  logic clk = 0;
  logic rst_b = 0;
  logic vld = 0;
  logic [13:0] ins = 14'h0000;
  logic [7:0] frd;
  logic fwe, pcl, dsc, zf, hrdy, hresp;
  logic [6:0] fad;
  logic [7:0] fwd, acc;
  logic [14:0] pc;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  int mismatches = 0;
  int check_count = 0;

  fre_exec i_fre_exec (.mclk_in(clk), .rst_b_in(rst_b),
    .instr_valid_in(vld), .instr_in(ins), .file_rdata_in(frd),
    .file_we_out(fwe), .file_addr_out(fad), .file_wdata_out(fwd),
    .acc_out(acc), .zero_out(zf), .pc_out(pc), .pc_load_out(pcl),
    .discard_out(dsc), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
    .hresp_out(hresp), .hrdata_out(hrdata));

  fre_mem_model i_fre_mem_model (.mclk_in(clk), .valid_in(vld),
    .raddr_in(ins[6:0]), .rdata_out(frd), .we_in(fwe),
    .waddr_in(fad), .wdata_in(fwd));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ****
  // Shared tasks
  // ****
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      mismatches++;
    end
  endtask

  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task issue(input logic [13:0] w);
    @(posedge clk);
    vld <= 1'b1;
    ins <= w;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask

  // ****
  // Scenarios
  // ****
  task t_comp;
    i_fre_mem_model.mem[5] = 8'h5A;
    i_fre_mem_model.mem[6] = 8'hFF;
    issue({`FRE_OPC_COMPLEMENT_FILE, 1'b0, 7'h05});
    chk("acc", 32'hA5, acc);
    chk("zero", 32'h0, zf);
    chk("we", 32'h0, fwe);
    issue({`FRE_OPC_COMPLEMENT_FILE, 1'b1, 7'h05});
    chk("wr", 32'h85A5, {fwe, fad, fwd});
    issue({`FRE_OPC_COMPLEMENT_FILE, 1'b0, 7'h06});
    chk("acc zero", 32'h100, {zf, acc});
    $display("complement done");
  endtask

  task t_clr;
    ahb(1'b1, 32'h04, 32'h0);
    issue({`FRE_OPC_CLR, 1'b1, 7'h7F});
    chk("clear_file", 32'h1FF00, {zf, fwe, fad, fwd});
    ahb(1'b1, 32'h04, 32'h0);
    ahb(1'b1, 32'h00, 32'h77);
    issue({`FRE_OPC_CLR, 1'b0, 7'h00});
    chk("clear_accumulator", 32'h100, {zf, acc});
    $display("clear done");
  endtask

  task t_dec;
    i_fre_mem_model.mem[9] = 8'h01;
    issue({`FRE_OPC_DECREMENT_FILE, 1'b0, 7'h09});
    chk("dec acc", 32'h100, {zf, acc});
    i_fre_mem_model.mem[9] = 8'h00;
    issue({`FRE_OPC_DECREMENT_FILE, 1'b1, 7'h09});
    chk("dec wr", 32'h89FF, {zf, fwe, fad, fwd});
    $display("decrement done");
  endtask

  task t_skip;
    ahb(1'b1, 32'h00, 32'h11);
    ahb(1'b1, 32'h04, 32'h1);
    i_fre_mem_model.mem[3] = 8'h02;
    issue({`FRE_OPC_DECREMENT_SKIP_ZERO, 1'b1, 7'h03});
    chk("dsz nz", 32'h301, {dsc, zf, fwe, fwd});
    i_fre_mem_model.mem[3] = 8'h01;
    issue({`FRE_OPC_DECREMENT_SKIP_ZERO, 1'b0, 7'h03});
    chk("dsz z", 32'h600, {dsc, zf, fwe, acc});
    ahb(1'b1, 32'h00, 32'h11);
    issue({`FRE_OPC_CLR, 1'b0, 7'h00});
    chk("dropped", 32'h0111, {dsc, zf, acc});
    ahb(1'b1, 32'h04, 32'h0);
    i_fre_mem_model.mem[4] = 8'hFF;
    issue({`FRE_OPC_INCREMENT_SKIP_ZERO, 1'b1, 7'h04});
    chk("isz z", 32'h500, {dsc, zf, fwe, fwd});
    issue({`FRE_OPC_CLR, 1'b0, 7'h00});
    chk("dropped2", 32'h0011, {dsc, zf, acc});
    i_fre_mem_model.mem[4] = 8'hFD;
    issue({`FRE_OPC_INCREMENT_SKIP_ZERO, 1'b0, 7'h04});
    chk("isz nz", 32'h00FE, {dsc, zf, acc});
    $display("skip done");
  endtask

  task t_jump;
    ahb(1'b1, 32'h08, 32'h5B);
    issue({`FRE_OPC_JUMP, 11'h4C3});
    chk("pcl", 32'h1, pcl);
    chk("pc", {17'h0, 4'hB, 11'h4C3}, pc);
    chk("dsc", 32'h1, dsc);
    issue({`FRE_OPC_CLR, 1'b0, 7'h00});
    chk("flush", 32'h0FE, {dsc, pcl, acc});
    ahb(1'b0, 32'h0C, 32'h0);
    chk("pc reg", {17'h0, 4'hB, 11'h4C3}, rd);
    ahb(1'b0, 32'h08, 32'h0);
    chk("latch reg", 32'h5B, rd);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, hresp);
    $display("jump done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    chk("reset", 32'h1, {pc, acc, zf, hrdy});
    rst_b <= 1'b1;
    t_comp();
    t_clr();
    t_dec();
    t_skip();
    t_jump();
    finish_test();
  end
endmodule
